// ===== cpu_status_control_defs.svh
/*
  Offsets, field positions and reset values for the CPU status and
  core control register bank. Assumes byte addresses on a 32-bit Wishbone bus.
*/
`ifndef CPU_STATUS_CONTROL_DEFS_SVH
`define CPU_STATUS_CONTROL_DEFS_SVH

`define OFS_FLAG 8'h00
`define OFS_CORE 8'h04
`define OFS_CTX 8'h08
`define OFS_YPAGE 8'h0C

`define FL_OVF_A 15
`define FL_CLIP_A 13
`define FL_EITHER_OVF 11
`define FL_EITHER_CLIP 10
`define FL_DO_RUN 9
`define FL_HALF_CARRY 8
`define FL_PRIO_HI 7
`define FL_PRIO_LO 5
`define FL_REP_RUN 4
`define FL_NEG 3
`define FL_OV 2
`define FL_ZERO 1
`define FL_CARRY 0

`define CC_VAR 15
`define CC_MUL_HI 13
`define CC_MUL_LO 12
`define CC_EXIT 11
`define CC_DEPTH_HI 10
`define CC_DEPTH_LO 8
`define CC_CLIP_A 7
`define CC_CLIP_B 6
`define CC_CLIP_ST 5
`define CC_CLIP_W 4
`define CC_PRIO_TOP 3
`define CC_FRAME 2
`define CC_ROUND 1
`define CC_INT 0

`define CTX_CUR_HI 10
`define CTX_CUR_LO 8
`define CTX_MAN_HI 2
`define CTX_MAN_LO 0

`define FLAG_RST 16'h0000
`define CORE_RST 16'h0020
`define YPAGE_RST 8'h01
`define PRIO_MASKED 3'h7

`endif

// ===== cpu_status_control_pkg.sv
/*
  Types shared by the register bank and its surroundings.
  Assumes the execution core drives the update structs synchronously.
*/
`default_nettype none
package cpu_status_control_pkg;

  typedef enum logic [1:0] {
    MUL_SIGNED = 2'h0,
    MUL_UNSIGNED = 2'h1,
    MUL_MIXED = 2'h2,
    MUL_RESERVED = 2'h3
  } mul_mode_t;

  typedef struct packed {
    logic valid;
    logic byte_op;
    logic carry_msb;
    logic carry_nib;
    logic carry_byte;
    logic negative;
    logic overflow;
    logic zero;
    logic keep_zero;
  } alu_upd_t;

  typedef struct packed {
    logic [1:0] wr;
    logic [1:0] ovf;
    logic [1:0] sat;
  } acc_evt_t;

  typedef struct packed {
    logic valid;
    logic [3:0] level;
  } ipl_load_t;

  typedef struct packed {
    logic do_active;
    logic repeat_active;
    logic [2:0] do_depth;
    logic frame_active;
    logic [2:0] cur_ctx;
    logic [2:0] man_ctx;
  } core_stat_t;

  typedef struct packed {
    logic var_latency;
    mul_mode_t mul_mode;
    logic clip_a;
    logic clip_b;
    logic clip_store;
    logic clip_wide;
    logic round_biased;
    logic int_mul;
  } dsp_cfg_t;

endpackage
`default_nettype wire

// ===== cpu_status_control_regs.sv
/*
  CPU flag, core configuration, context status and Y page registers behind a
  classic Wishbone slave. Assumes the core datapath sends flag events and loop
  and context status synchronously to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_control_defs.svh"

module cpu_status_control_regs
  import cpu_status_control_pkg::*;
#(
  parameter bit YPAGE_IMPL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire alu_upd_t alu_upd,
  input wire acc_evt_t acc_evt,
  input wire ipl_load_t ipl_load,
  input wire core_stat_t core_stat,
  input wire logic nesting_disable,
  output logic [3:0] cpu_priority,
  output logic user_irq_block,
  output dsp_cfg_t dsp_cfg,
  output logic early_loop_exit,
  output logic frame_full_range,
  output logic [7:0] y_page
);

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] sel);
    merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic blocks_user(input logic top, input logic [2:0] low);
    blocks_user = top | (low == `PRIO_MASKED);
  endfunction

  function automatic dsp_cfg_t unpack_cfg(input logic [15:0] v);
    unpack_cfg.var_latency = v[`CC_VAR];
    unpack_cfg.mul_mode = mul_mode_t'(v[`CC_MUL_HI:`CC_MUL_LO]);
    unpack_cfg.clip_a = v[`CC_CLIP_A];
    unpack_cfg.clip_b = v[`CC_CLIP_B];
    unpack_cfg.clip_store = v[`CC_CLIP_ST];
    unpack_cfg.clip_wide = v[`CC_CLIP_W];
    unpack_cfg.round_biased = v[`CC_ROUND];
    unpack_cfg.int_mul = v[`CC_INT];
  endfunction

  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic [1:0] ovf_ff;
  logic [1:0] clip_ff;
  logic half_carry_ff;
  logic neg_ff;
  logic ov_ff;
  logic zero_ff;
  logic carry_ff;
  logic [2:0] prio_low_ff;
  logic prio_top_ff;
  logic irq_block_ff;
  dsp_cfg_t cfg_ff;
  logic exit_ff;
  logic frame_ff;
  logic [7:0] ypage_ff;
  logic [2:0] nxt_prio_low;
  logic nxt_prio_top;
  logic req;
  logic wr_flag;
  logic wr_core;
  logic wr_ypage;
  logic [15:0] flag_rd;
  logic [15:0] core_rd;
  logic [15:0] ctx_rd;
  logic [15:0] flag_wd;
  logic [15:0] core_wd;

  // one-cycle answer; the ack_ff term keeps a held request from being taken twice
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_flag = req & wb_we_i & hit(wb_adr_i, `OFS_FLAG);
  assign wr_core = req & wb_we_i & hit(wb_adr_i, `OFS_CORE);
  assign wr_ypage = req & wb_we_i & hit(wb_adr_i, `OFS_YPAGE);

  always_comb begin
    flag_rd = 16'h0000;
    flag_rd[`FL_OVF_A] = ovf_ff[0];
    flag_rd[`FL_OVF_A-1] = ovf_ff[1];
    flag_rd[`FL_CLIP_A] = clip_ff[0];
    flag_rd[`FL_CLIP_A-1] = clip_ff[1];
    flag_rd[`FL_EITHER_OVF] = |ovf_ff;
    flag_rd[`FL_EITHER_CLIP] = |clip_ff;
    flag_rd[`FL_DO_RUN] = core_stat.do_active;
    flag_rd[`FL_HALF_CARRY] = half_carry_ff;
    flag_rd[`FL_PRIO_HI:`FL_PRIO_LO] = prio_low_ff;
    flag_rd[`FL_REP_RUN] = core_stat.repeat_active;
    flag_rd[`FL_NEG] = neg_ff;
    flag_rd[`FL_OV] = ov_ff;
    flag_rd[`FL_ZERO] = zero_ff;
    flag_rd[`FL_CARRY] = carry_ff;
  end

  always_comb begin
    core_rd = 16'h0000;
    core_rd[`CC_VAR] = cfg_ff.var_latency;
    core_rd[`CC_MUL_HI:`CC_MUL_LO] = cfg_ff.mul_mode;
    core_rd[`CC_DEPTH_HI:`CC_DEPTH_LO] = core_stat.do_depth;
    core_rd[`CC_CLIP_A] = cfg_ff.clip_a;
    core_rd[`CC_CLIP_B] = cfg_ff.clip_b;
    core_rd[`CC_CLIP_ST] = cfg_ff.clip_store;
    core_rd[`CC_CLIP_W] = cfg_ff.clip_wide;
    core_rd[`CC_PRIO_TOP] = prio_top_ff;
    core_rd[`CC_FRAME] = core_stat.frame_active;
    core_rd[`CC_ROUND] = cfg_ff.round_biased;
    core_rd[`CC_INT] = cfg_ff.int_mul;
  end

  always_comb begin
    ctx_rd = 16'h0000;
    ctx_rd[`CTX_CUR_HI:`CTX_CUR_LO] = core_stat.cur_ctx;
    ctx_rd[`CTX_MAN_HI:`CTX_MAN_LO] = core_stat.man_ctx;
  end

  always_comb begin
    nxt_rdat = 32'h0000_0000;
    // unmapped offsets answer with zero data
    if (hit(wb_adr_i, `OFS_FLAG)) begin
      nxt_rdat = {16'h0000, flag_rd};
    end else if (hit(wb_adr_i, `OFS_CORE)) begin
      nxt_rdat = {16'h0000, core_rd};
    end else if (hit(wb_adr_i, `OFS_CTX)) begin
      nxt_rdat = {16'h0000, ctx_rd};
    end else if (hit(wb_adr_i, `OFS_YPAGE)) begin
      nxt_rdat = {24'h00_0000, ypage_ff};
    end
  end

  assign flag_wd = merge(flag_rd, wb_dat_i[15:0], wb_sel_i[1:0]);
  assign core_wd = merge(core_rd, wb_dat_i[15:0], wb_sel_i[1:0]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else if (ce) begin
      ack_ff <= req;
      if (req && !wb_we_i) begin
        rdat_ff <= nxt_rdat;
      end
    end
  end

  // hardware events win over a software write in the same cycle
  for (genvar i = 0; i < 2; i++) begin : g_acc
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        ovf_ff[i] <= 1'b0;
      end else if (ce) begin
        if (acc_evt.wr[i]) begin
          ovf_ff[i] <= acc_evt.ovf[i];
        end else if (wr_flag && wb_sel_i[1]) begin
          ovf_ff[i] <= flag_wd[`FL_OVF_A-i];
        end
      end
    end

    // bit-set or bit-clear on one sticky flag rewrites the other too: a race
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        clip_ff[i] <= 1'b0;
      end else if (ce) begin
        if (acc_evt.sat[i]) begin
          clip_ff[i] <= 1'b1;
        end else if (wr_flag && wb_sel_i[1]) begin
          if (!wb_dat_i[`FL_EITHER_CLIP]) begin
            clip_ff[i] <= 1'b0;
          end else begin
            clip_ff[i] <= flag_wd[`FL_CLIP_A-i];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_carry_ff <= 1'b0;
      neg_ff <= 1'b0;
      ov_ff <= 1'b0;
      zero_ff <= 1'b0;
      carry_ff <= 1'b0;
    end else if (ce) begin
      if (alu_upd.valid) begin
        half_carry_ff <= alu_upd.byte_op ? alu_upd.carry_nib : alu_upd.carry_byte;
        neg_ff <= alu_upd.negative;
        ov_ff <= alu_upd.overflow;
        // chained ops keep an earlier zero so a wide result reads zero only if all parts are
        if (!alu_upd.zero) begin
          zero_ff <= 1'b0;
        end else if (!alu_upd.keep_zero) begin
          zero_ff <= 1'b1;
        end
        carry_ff <= alu_upd.carry_msb;
      end else if (wr_flag) begin
        half_carry_ff <= flag_wd[`FL_HALF_CARRY];
        neg_ff <= flag_wd[`FL_NEG];
        ov_ff <= flag_wd[`FL_OV];
        zero_ff <= flag_wd[`FL_ZERO];
        carry_ff <= flag_wd[`FL_CARRY];
      end
    end
  end

  always_comb begin
    nxt_prio_low = prio_low_ff;
    nxt_prio_top = prio_top_ff;
    if (ipl_load.valid) begin
      nxt_prio_low = ipl_load.level[2:0];
      nxt_prio_top = ipl_load.level[3];
    end else begin
      if (wr_flag && wb_sel_i[0] && !nesting_disable) begin
        nxt_prio_low = flag_wd[`FL_PRIO_HI:`FL_PRIO_LO];
      end
      // top bit can only be cleared by software
      if (wr_core && wb_sel_i[0] && !wb_dat_i[`CC_PRIO_TOP]) begin
        nxt_prio_top = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_low_ff <= 3'h0;
      prio_top_ff <= 1'b0;
      irq_block_ff <= 1'b0;
    end else if (ce) begin
      prio_low_ff <= nxt_prio_low;
      prio_top_ff <= nxt_prio_top;
      irq_block_ff <= blocks_user(nxt_prio_top, nxt_prio_low);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= unpack_cfg(`CORE_RST);
    end else if (ce) begin
      if (wr_core) begin
        cfg_ff <= unpack_cfg(core_wd);
        // reserved signedness code is refused, previous mode kept
        if (core_wd[`CC_MUL_HI:`CC_MUL_LO] == MUL_RESERVED) begin
          cfg_ff.mul_mode <= cfg_ff.mul_mode;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exit_ff <= 1'b0;
    end else if (ce) begin
      exit_ff <= wr_core & wb_sel_i[1] & wb_dat_i[`CC_EXIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_ff <= 1'b0;
    end else if (ce) begin
      frame_ff <= core_stat.frame_active;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ypage_ff <= `YPAGE_RST;
    end else if (ce) begin
      if (YPAGE_IMPL && wr_ypage && wb_sel_i[0]) begin
        ypage_ff <= wb_dat_i[7:0];
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign cpu_priority = {prio_top_ff, prio_low_ff};
  assign user_irq_block = irq_block_ff;
  assign dsp_cfg = cfg_ff;
  assign early_loop_exit = exit_ff;
  assign frame_full_range = frame_ff;
  assign y_page = ypage_ff;

endmodule
`default_nettype wire

// ===== cpu_status_control_regs_props.sv
/* Port checker for the status and control register bank.
   Assumes one core_clk domain and that ce gates every state change. */
`timescale 1ns/1ps
`default_nettype none
module cpu_status_control_regs_props
  import cpu_status_control_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ipl_load_t ipl_load,
  input wire core_stat_t core_stat,
  input wire logic nesting_disable,
  input wire logic [3:0] cpu_priority,
  input wire logic user_irq_block,
  input wire logic early_loop_exit,
  input wire logic frame_full_range
);
  wire req = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ack_after_req: assert property (req |=> wb_ack_o) else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_block_level: assert property (user_irq_block == (cpu_priority[3] || cpu_priority[2:0] == 3'h7))
    else $error("irq block mismatch");
  a_ipl_load: assert property (ce && ipl_load.valid |=> cpu_priority == $past(ipl_load.level))
    else $error("priority load lost");
  a_low_locked: assert property (ce && nesting_disable && !ipl_load.valid |=> $stable(cpu_priority[2:0]))
    else $error("low priority changed while locked");
  a_exit_pulse: assert property (req && wb_we_i && wb_adr_i[7:2] == 6'h01 && wb_sel_i[1] && wb_dat_i[11]
    |=> early_loop_exit) else $error("exit pulse missing");
  a_exit_cause: assert property (early_loop_exit |-> wb_ack_o && $past(wb_we_i))
    else $error("exit pulse without write");
  a_frame_copy: assert property (ce |=> frame_full_range == $past(core_stat.frame_active))
    else $error("frame range not following status");
  a_ctx_read: assert property (req && !wb_we_i && wb_adr_i[7:2] == 6'h02 |=> wb_dat_o[15:0] ==
    {5'h00, $past(core_stat.cur_ctx), 5'h00, $past(core_stat.man_ctx)}) else $error("context read wrong");
  a_ce_freeze: assert property (!ce |=> $stable(cpu_priority) && $stable(wb_ack_o))
    else $error("state moved while ce low");
  c_write: cover property (req && wb_we_i);
  c_exit: cover property (early_loop_exit);
  c_top_block: cover property (user_irq_block && cpu_priority[3]);
endmodule
bind cpu_status_control_regs cpu_status_control_regs_props props_u (.*);
`default_nettype wire

// ===== cpu_status_control_regs_test.sv
/* Self-checking bench for the register bank.
   Assumes the bank answers one Wishbone request per idle-separated cycle. */
`timescale 1ns/1ps
`default_nettype none
module cpu_status_control_regs_test
  import cpu_status_control_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, nesting_disable = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  alu_upd_t alu_upd = '0;
  acc_evt_t acc_evt = '0;
  ipl_load_t ipl_load = '0;
  core_stat_t core_stat = '0;
  logic wb_ack_o, user_irq_block, early_loop_exit, frame_full_range, xit;
  logic [3:0] cpu_priority;
  logic [7:0] y_page;
  logic [15:0] rdat;
  dsp_cfg_t dsp_cfg;
  int err_total = 0;
  int checked = 0;
  always #4 core_clk = ~core_clk;
  cpu_status_control_regs #(.YPAGE_IMPL(1'b1)) dut_u (.*);
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= s;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    rdat = wb_dat_o[15:0];
    xit = early_loop_exit;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, 4'h3);
    chk(rdat, e);
  endtask
  // events last exactly one cycle, as the core would pulse them
  task automatic ev(input alu_upd_t a, input acc_evt_t c, input ipl_load_t p);
    @(posedge core_clk);
    alu_upd <= a;
    acc_evt <= c;
    ipl_load <= p;
    @(posedge core_clk);
    alu_upd <= '0;
    acc_evt <= '0;
    ipl_load <= '0;
    #1;
  endtask
  task automatic t_reset;
    rd(8'h00, 16'h0000);
    rd(8'h04, 16'h0020);
    rd(8'h08, 16'h0000);
    rd(8'h0C, 16'h0001);
    rd(8'h10, 16'h0000);
    chk({7'h00, dsp_cfg}, 16'h0008);
  endtask
  task automatic t_acc;
    ev('0, 6'h16, '0);
    rd(8'h00, 16'h9C00);
    bus(1'b1, 8'h00, 16'h8000, 4'h2);
    rd(8'h00, 16'h8800);
    ev('0, 6'h01, '0);
    rd(8'h00, 16'hAC00);
    bus(1'b1, 8'h00, 16'h1400, 4'h2);
    rd(8'h00, 16'h1400);
    bus(1'b1, 8'h00, 16'h0000, 4'h2);
  endtask
  task automatic t_alu;
    ev(9'h15E, '0, '0);
    rd(8'h00, 16'h010F);
    ev(9'h1A3, '0, '0);
    rd(8'h00, 16'h0102);
    ev(9'h190, '0, '0);
    rd(8'h00, 16'h0000);
  endtask
  task automatic t_prio;
    bus(1'b1, 8'h00, 16'h00E0, 4'h1);
    chk({11'h000, user_irq_block, cpu_priority}, 16'h0017);
    nesting_disable <= 1'b1;
    bus(1'b1, 8'h00, 16'h0020, 4'h1);
    chk({11'h000, user_irq_block, cpu_priority}, 16'h0017);
    rd(8'h00, 16'h00E0);
    nesting_disable <= 1'b0;
    ev('0, '0, 5'h18);
    chk({11'h000, user_irq_block, cpu_priority}, 16'h0018);
    rd(8'h04, 16'h0028);
    bus(1'b1, 8'h04, 16'h0020, 4'h1);
    chk({11'h000, user_irq_block, cpu_priority}, 16'h0000);
  endtask
  task automatic t_status;
    core_stat <= 12'hFE1;
    rd(8'h00, 16'h0210);
    rd(8'h04, 16'h0724);
    rd(8'h08, 16'h0401);
    chk({15'h0000, frame_full_range}, 16'h0001);
    core_stat <= '0;
  endtask
  task automatic t_cfg;
    logic [1:0] em;
    bus(1'b1, 8'h04, 16'h80F3, 4'h3);
    chk({7'h00, dsp_cfg}, 16'h013F);
    for (int m = 0; m < 4; m++) begin
      em = (m == 3) ? 2'h2 : 2'(m);
      bus(1'b1, 8'h04, {2'h0, 2'(m), 12'h800}, 4'h3);
      chk({15'h0000, xit}, 16'h0001);
      chk({7'h00, dsp_cfg}, {8'h00, em, 6'h00});
      rd(8'h04, {2'h0, em, 12'h000});
    end
  endtask
  // a priority load while ce is low must be lost, not deferred
  task automatic t_hold;
    ce <= 1'b0;
    ev('0, '0, 5'h1F);
    ce <= 1'b1;
    chk({11'h000, user_irq_block, cpu_priority}, 16'h0000);
    rd(8'h00, 16'h0000);
  endtask
  task automatic t_ypage;
    bus(1'b1, 8'h0C, 16'h00AB, 4'h1);
    chk({8'h00, y_page}, 16'h00AB);
    rd(8'h0C, 16'h00AB);
  endtask
  task automatic summarize;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_acc();
    t_alu();
    t_prio();
    t_status();
    t_cfg();
    t_hold();
    t_ypage();
    summarize();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
